// ==== srom_cfg_host.sv ====
// far-side model: configuring logic that clocks the readout and shares the reset wire
`timescale 1ns/1ps
`default_nettype none
module srom_cfg_host (
	// clock and control
	input wire logic clk_in,
	input wire logic hold_in,
	// memory side
	input wire logic oe_drive_in,
	input wire logic data_in,
	input wire logic data_oe_in,
	output logic cfg_clk_out,
	output logic oe_wire_out,
	output logic data_wire_out
);
	logic last_r;
	initial begin
		cfg_clk_out = 1'b0;
		last_r = 1'b0;
	end
	// open-drain wire with pull-up, low if either side pulls
	assign oe_wire_out = !(oe_drive_in || hold_in);
	// a floating data line shows the inverse of its last level, never a stale copy
	always @(posedge clk_in) begin
		if (data_oe_in) begin
			last_r <= data_in;
		end
	end
	assign data_wire_out = data_oe_in ? data_in : !last_r;
	// clock runs only within a frame, four cycles high and four low
	task automatic step(input int n);
		repeat (n) begin
			cfg_clk_out = 1'b1;
			repeat (4) @(negedge clk_in);
			cfg_clk_out = 1'b0;
			repeat (4) @(negedge clk_in);
		end
	endtask
endmodule
`default_nettype wire

// ==== srom_pkg.sv ====
// constants, state codes and carrier types of the serial configuration memory
`default_nettype none
package srom_pkg;
	// ************************************************************
	// timing
	// ************************************************************
	localparam int SYS_CLK_MHZ = 200;
	localparam int POR_HOLD_NS = 100;
	localparam int CFG_PULSE_NS = 1000;
	localparam int POR_HOLD_CYC = (POR_HOLD_NS * SYS_CLK_MHZ + 999) / 1000;
	localparam int CFG_PULSE_CYC = (CFG_PULSE_NS * SYS_CLK_MHZ + 999) / 1000;
	localparam int TIMER_W = 8;

	// ************************************************************
	// storage and fifo
	// ************************************************************
	localparam int MEM_WORDS = 256;
	localparam int WORD_W = 8;
	localparam int FIFO_DEPTH = 8;

	// ************************************************************
	// test access port
	// ************************************************************
	localparam int IR_W = 8;
	localparam int ID_W = 32;
	localparam int BYP_W = 1;
	localparam logic [IR_W-1:0] IR_CAPTURE = 8'h01;
	localparam logic [IR_W-1:0] INS_BYPASS = 8'hff;
	localparam logic [IR_W-1:0] INS_IDCODE = 8'h01;
	localparam logic [IR_W-1:0] INS_ISP_ENTER = 8'he8;
	localparam logic [IR_W-1:0] INS_PROGRAM = 8'hea;
	localparam logic [IR_W-1:0] INS_CONFIG = 8'hee;
	// arbitrary identification value
	localparam logic [ID_W-1:0] ID_VALUE = 32'h0a5a_5001;

	typedef enum logic [15:0] {
		TAP_RESET = 16'h0001,
		TAP_IDLE = 16'h0002,
		TAP_SEL_DR = 16'h0004,
		TAP_CAP_DR = 16'h0008,
		TAP_SH_DR = 16'h0010,
		TAP_EX1_DR = 16'h0020,
		TAP_PA_DR = 16'h0040,
		TAP_EX2_DR = 16'h0080,
		TAP_UP_DR = 16'h0100,
		TAP_SEL_IR = 16'h0200,
		TAP_CAP_IR = 16'h0400,
		TAP_SH_IR = 16'h0800,
		TAP_EX1_IR = 16'h1000,
		TAP_PA_IR = 16'h2000,
		TAP_EX2_IR = 16'h4000,
		TAP_UP_IR = 16'h8000
	} srom_tap_t;

	// ************************************************************
	// pin groups
	// ************************************************************
	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
	} srom_jtag_t;

	typedef struct packed {
		logic clk;
		logic sel;
		logic ce_n;
		logic oe_rst_n;
	} srom_cfg_t;
endpackage
`default_nettype wire

// ==== srom_properties.sv ====
// checker of the readout, cascade, reset wire and test port timing
`timescale 1ns/1ps
`default_nettype none
module srom_properties (
	// clock and reset
	input wire logic SYS_CLK_IN,
	input wire logic RSTN_IN,
	// configuration port
	input wire logic CFG_CLK_IN,
	input wire logic CHIP_SEL_N_IN,
	input wire logic OE_RESET_N_IN,
	input wire logic OE_RESET_N_OE_OUT,
	input wire logic SERIAL_DATA_OE_OUT,
	input wire logic CASCADE_SELECT_N_OUT,
	input wire logic CONFIG_PULSE_N_OUT,
	input wire logic CONFIG_PULSE_N_OE_OUT,
	input wire logic STANDBY_OUT,
	// test port
	input wire logic TCK_IN,
	input wire logic TDO_OUT,
	input wire logic ISP_ACTIVE_OUT
);
	logic [8:0] pulse_cnt_r;
	logic [8:0] pulse_cnt_nxt;
	default clocking @(posedge SYS_CLK_IN); endclocking
	default disable iff (!RSTN_IN);
	// ************************************************************
	// helper: length of the configuration pulse
	// ************************************************************
	always_comb begin
		pulse_cnt_nxt = CONFIG_PULSE_N_OE_OUT ? pulse_cnt_r + 9'h001 : 9'h000;
	end
	always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			pulse_cnt_r <= 9'h000;
		end else begin
			pulse_cnt_r <= pulse_cnt_nxt;
		end
	end
	// ************************************************************
	// properties
	// ************************************************************
	a_oe_reset_hold: assert property ($rose(RSTN_IN) |-> OE_RESET_N_OE_OUT [*8])
		else $error("reset wire released too early");
	a_data_float_oe: assert property ((!OE_RESET_N_IN) [*4] |-> !SERIAL_DATA_OE_OUT)
		else $error("data driven while reset wire low");
	a_standby_float: assert property (CHIP_SEL_N_IN [*4] |-> !SERIAL_DATA_OE_OUT && STANDBY_OUT)
		else $error("data driven or no standby while deselected");
	a_cascade_off: assert property (CHIP_SEL_N_IN || !OE_RESET_N_IN |-> CASCADE_SELECT_N_OUT)
		else $error("cascade low while disabled");
	a_cascade_cause: assert property ($fell(CASCADE_SELECT_N_OUT) |->
		($past(CFG_CLK_IN) || $past(CFG_CLK_IN, 2)) && !SERIAL_DATA_OE_OUT == 1'b0)
		else $error("cascade fell without a clock step");
	a_isp_float: assert property (ISP_ACTIVE_OUT [*4] |-> !SERIAL_DATA_OE_OUT)
		else $error("data driven during programming");
	a_cfg_pulse_len: assert property ($fell(CONFIG_PULSE_N_OE_OUT) |->
		pulse_cnt_r == 9'(srom_pkg::CFG_PULSE_CYC))
		else $error("configuration pulse length wrong");
	a_cfg_pin_low: assert property (CONFIG_PULSE_N_OE_OUT |-> !CONFIG_PULSE_N_OUT)
		else $error("configuration pulse not low");
	a_tdo_on_fall: assert property ($changed(TDO_OUT) |-> !$past(TCK_IN, 2))
		else $error("test output moved outside a clock fall");
endmodule
bind srom_top srom_properties chk_u (.SYS_CLK_IN(SYS_CLK_IN), .RSTN_IN(RSTN_IN), .CFG_CLK_IN(CFG_CLK_IN),
	.CHIP_SEL_N_IN(CHIP_SEL_N_IN), .OE_RESET_N_IN(OE_RESET_N_IN), .OE_RESET_N_OE_OUT(OE_RESET_N_OE_OUT),
	.SERIAL_DATA_OE_OUT(SERIAL_DATA_OE_OUT), .CASCADE_SELECT_N_OUT(CASCADE_SELECT_N_OUT),
	.CONFIG_PULSE_N_OUT(CONFIG_PULSE_N_OUT), .CONFIG_PULSE_N_OE_OUT(CONFIG_PULSE_N_OE_OUT),
	.STANDBY_OUT(STANDBY_OUT), .TCK_IN(TCK_IN), .TDO_OUT(TDO_OUT), .ISP_ACTIVE_OUT(ISP_ACTIVE_OUT));
`default_nettype wire

// ==== srom_top.sv ====
// serial configuration memory readout, cascade control and boundary-scan port
//
// Function
// - counter steps on selected clock rise, enabled
// - reset line low: counter reset, data floats
// - reset line open-drain, pulled low in reset
// - chip select high: standby, counter reset, float
// - config instruction pulses config output low
// - cascade low only when enabled past last
// - cascade high at once when disabled
// - data floats during in-system programming
// - tap follows mode select on test clock rise
// - test clock paces all test logic
// - all registers shift in and out serially
// - undriven test pins other than the clock read as one
// - paced clock toggles only while data available, or whenever running with decompression off
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// buffer between programming port and storage
// ************************************************************
module srom_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// fill side
	input wire logic s_valid_in,
	output logic s_ready_out,
	input wire logic [WIDTH-1:0] s_data_in,
	// drain side
	output logic m_valid_out,
	input wire logic m_ready_in,
	output logic [WIDTH-1:0] m_data_out
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW:0] wr_r, wr_nxt, rd_r, rd_nxt;
	logic push, pop;

	// extra pointer bit tells full from empty
	assign s_ready_out = (wr_r[PW] == rd_r[PW]) || (wr_r[PW-1:0] != rd_r[PW-1:0]);
	assign m_valid_out = wr_r != rd_r;
	assign m_data_out = mem[rd_r[PW-1:0]];
	assign push = s_valid_in & s_ready_out;
	assign pop = m_valid_out & m_ready_in;

	// pointer step
	always_comb begin
		wr_nxt = push ? wr_r + 1'b1 : wr_r;
		rd_nxt = pop ? rd_r + 1'b1 : rd_r;
	end

	// pointer registers
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_r <= '0;
			rd_r <= '0;
		end else begin
			wr_r <= wr_nxt;
			rd_r <= rd_nxt;
		end
	end

	// storage has no reset, nothing reads an empty slot
	always_ff @(posedge clk_in) begin
		if (push) begin
			mem[wr_r[PW-1:0]] <= s_data_in;
		end
	end
endmodule

// ************************************************************
// top
// ************************************************************
module srom_top #(
	parameter int WORDS = srom_pkg::MEM_WORDS,
	parameter int FIFO_DEPTH = srom_pkg::FIFO_DEPTH,
	parameter logic [srom_pkg::ID_W-1:0] ID_CODE = srom_pkg::ID_VALUE
) (
	// clock and reset
	input wire logic SYS_CLK_IN,
	input wire logic RSTN_IN,
	// configuration port
	input wire logic CFG_CLK_IN,
	input wire logic CFG_CLK_SEL_IN,
	input wire logic CHIP_SEL_N_IN,
	input wire logic DECOMP_EN_IN,
	input wire logic OE_RESET_N_IN,
	output logic OE_RESET_N_OUT,
	output logic OE_RESET_N_OE_OUT,
	output logic SERIAL_DATA_OUT,
	output logic SERIAL_DATA_OE_OUT,
	output logic CASCADE_SELECT_N_OUT,
	output logic CONFIG_PULSE_N_OUT,
	output logic CONFIG_PULSE_N_OE_OUT,
	output logic PACED_CLOCK_OUTPUT_OUT,
	output logic STANDBY_OUT,
	// boundary-scan port
	input wire logic TCK_IN,
	input wire logic TMS_IN,
	input wire logic TDI_IN,
	output logic TDO_OUT,
	output logic TDO_OE_OUT,
	// programming status
	output logic ISP_ACTIVE_OUT,
	output logic PROG_READY_OUT
);
	localparam int WORD_W = srom_pkg::WORD_W;
	localparam int BITS = WORDS * WORD_W;
	localparam int AW = $clog2(BITS);
	localparam int WA = $clog2(WORDS);
	localparam int BW = $clog2(WORD_W);
	localparam logic [AW:0] LAST_ADDRESS_COUNT = (AW + 1)'(BITS - 1);
	localparam int TW = srom_pkg::TIMER_W;

	logic [WORD_W-1:0] mem [WORDS];
	// pin samples
	srom_pkg::srom_jtag_t jtag_r, jtag_nxt, jtag_d_r;
	srom_pkg::srom_cfg_t cfg_r, cfg_nxt, cfg_d_r;
	logic tck_rise, tck_fall, cfg_rise;
	// reset hold
	logic por_r, por_nxt;
	logic [TW-1:0] por_cnt_r, por_cnt_nxt;
	// test access port
	srom_pkg::srom_tap_t tap_r, tap_nxt;
	logic [srom_pkg::IR_W-1:0] ir_r, ir_nxt, ir_sh_r, ir_sh_nxt;
	logic [srom_pkg::ID_W-1:0] dr_r, dr_nxt;
	logic tdo_r, tdo_nxt, tdo_oe_r, tdo_oe_nxt;
	logic push, cfg_start, isp_active;
	int dr_len;
	// config pulse
	logic [TW-1:0] pulse_cnt_r, pulse_cnt_nxt;
	// readout
	logic [AW:0] addr_r, addr_nxt;
	logic past_tc, enabled, run;
	logic data_r, data_nxt, data_oe_r, data_oe_nxt, standby_r, paced_r, paced_nxt;
	// programming
	logic [WA-1:0] wr_ptr_r, wr_ptr_nxt;
	logic prog_ready, fifo_valid;
	logic [WORD_W-1:0] fifo_data;

	// ************************************************************
	// pin sampling and edge detection
	// ************************************************************
	// pins are synchronous, one stage is enough for edges
	assign jtag_nxt = '{tck: TCK_IN, tms: TMS_IN, tdi: TDI_IN};
	assign cfg_nxt = '{clk: CFG_CLK_IN, sel: CFG_CLK_SEL_IN, ce_n: CHIP_SEL_N_IN, oe_rst_n: OE_RESET_N_IN};
	assign tck_rise = jtag_r.tck & ~jtag_d_r.tck;
	assign tck_fall = ~jtag_r.tck & jtag_d_r.tck;
	assign cfg_rise = cfg_r.clk & ~cfg_d_r.clk;

	// pin registers, idle level of open pins
	always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			// test clock rests low, so leaving reset shows no false edge
			jtag_r <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b1};
			jtag_d_r <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b1};
			cfg_r <= 4'h2;
			cfg_d_r <= 4'h2;
		end else begin
			jtag_r <= jtag_nxt;
			jtag_d_r <= jtag_r;
			cfg_r <= cfg_nxt;
			cfg_d_r <= cfg_r;
		end
	end

	// ************************************************************
	// internal reset hold
	// ************************************************************
	// memory holds the reset line low until its own reset is over
	always_comb begin
		por_cnt_nxt = por_cnt_r;
		por_nxt = por_r;
		if (por_r) begin
			por_cnt_nxt = por_cnt_r + 1'b1;
			if (por_cnt_r == TW'(srom_pkg::POR_HOLD_CYC - 1)) begin
				por_nxt = 1'b0;
			end
		end
	end

	always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			por_r <= 1'b1;
			por_cnt_r <= '0;
		end else begin
			por_r <= por_nxt;
			por_cnt_r <= por_cnt_nxt;
		end
	end

	assign OE_RESET_N_OUT = 1'b0;
	assign OE_RESET_N_OE_OUT = por_r;

	// ************************************************************
	// tap controller
	// ************************************************************
	// moves only on a test clock rise, by the sampled mode level
	always_comb begin
		tap_nxt = tap_r;
		if (tck_rise) begin
			case (tap_r)
				srom_pkg::TAP_RESET: tap_nxt = jtag_r.tms ? srom_pkg::TAP_RESET : srom_pkg::TAP_IDLE;
				srom_pkg::TAP_IDLE: tap_nxt = jtag_r.tms ? srom_pkg::TAP_SEL_DR : srom_pkg::TAP_IDLE;
				srom_pkg::TAP_SEL_DR: tap_nxt = jtag_r.tms ? srom_pkg::TAP_SEL_IR : srom_pkg::TAP_CAP_DR;
				srom_pkg::TAP_CAP_DR: tap_nxt = jtag_r.tms ? srom_pkg::TAP_EX1_DR : srom_pkg::TAP_SH_DR;
				srom_pkg::TAP_SH_DR: tap_nxt = jtag_r.tms ? srom_pkg::TAP_EX1_DR : srom_pkg::TAP_SH_DR;
				srom_pkg::TAP_EX1_DR: tap_nxt = jtag_r.tms ? srom_pkg::TAP_UP_DR : srom_pkg::TAP_PA_DR;
				srom_pkg::TAP_PA_DR: tap_nxt = jtag_r.tms ? srom_pkg::TAP_EX2_DR : srom_pkg::TAP_PA_DR;
				srom_pkg::TAP_EX2_DR: tap_nxt = jtag_r.tms ? srom_pkg::TAP_UP_DR : srom_pkg::TAP_SH_DR;
				srom_pkg::TAP_UP_DR: tap_nxt = jtag_r.tms ? srom_pkg::TAP_SEL_DR : srom_pkg::TAP_IDLE;
				srom_pkg::TAP_SEL_IR: tap_nxt = jtag_r.tms ? srom_pkg::TAP_RESET : srom_pkg::TAP_CAP_IR;
				srom_pkg::TAP_CAP_IR: tap_nxt = jtag_r.tms ? srom_pkg::TAP_EX1_IR : srom_pkg::TAP_SH_IR;
				srom_pkg::TAP_SH_IR: tap_nxt = jtag_r.tms ? srom_pkg::TAP_EX1_IR : srom_pkg::TAP_SH_IR;
				srom_pkg::TAP_EX1_IR: tap_nxt = jtag_r.tms ? srom_pkg::TAP_UP_IR : srom_pkg::TAP_PA_IR;
				srom_pkg::TAP_PA_IR: tap_nxt = jtag_r.tms ? srom_pkg::TAP_EX2_IR : srom_pkg::TAP_PA_IR;
				srom_pkg::TAP_EX2_IR: tap_nxt = jtag_r.tms ? srom_pkg::TAP_UP_IR : srom_pkg::TAP_SH_IR;
				srom_pkg::TAP_UP_IR: tap_nxt = jtag_r.tms ? srom_pkg::TAP_SEL_DR : srom_pkg::TAP_IDLE;
				default: tap_nxt = srom_pkg::TAP_RESET;
			endcase
		end
	end

	// ************************************************************
	// instruction and data registers
	// ************************************************************
	// data register length follows the current instruction
	always_comb begin
		if (ir_r == srom_pkg::INS_IDCODE) begin
			dr_len = srom_pkg::ID_W;
		end else if (ir_r == srom_pkg::INS_PROGRAM) begin
			dr_len = WORD_W;
		end else begin
			dr_len = srom_pkg::BYP_W;
		end
	end

	// capture, shift and update on test clock rise; tdo moves on fall
	always_comb begin
		ir_nxt = ir_r;
		ir_sh_nxt = ir_sh_r;
		dr_nxt = dr_r;
		push = 1'b0;
		cfg_start = 1'b0;
		tdo_nxt = tdo_r;
		tdo_oe_nxt = tdo_oe_r;
		if (tck_rise) begin
			case (tap_r)
				srom_pkg::TAP_RESET: ir_nxt = srom_pkg::INS_IDCODE;
				srom_pkg::TAP_CAP_IR: ir_sh_nxt = srom_pkg::IR_CAPTURE;
				srom_pkg::TAP_SH_IR: ir_sh_nxt = {jtag_r.tdi, ir_sh_r[srom_pkg::IR_W-1:1]};
				srom_pkg::TAP_UP_IR: begin
					ir_nxt = ir_sh_r;
					cfg_start = ir_sh_r == srom_pkg::INS_CONFIG;
				end
				srom_pkg::TAP_CAP_DR: begin
					if (ir_r == srom_pkg::INS_IDCODE) begin
						dr_nxt = ID_CODE;
					end else if (ir_r == srom_pkg::INS_PROGRAM) begin
						dr_nxt = {{(srom_pkg::ID_W - 1){1'b0}}, prog_ready};
					end else begin
						dr_nxt = '0;
					end
				end
				srom_pkg::TAP_SH_DR: begin
					dr_nxt = dr_r >> 1;
					dr_nxt[dr_len-1] = jtag_r.tdi;
				end
				srom_pkg::TAP_UP_DR: push = ir_r == srom_pkg::INS_PROGRAM;
				default: ;
			endcase
		end
		if (tck_fall) begin
			tdo_nxt = (tap_r == srom_pkg::TAP_SH_IR) ? ir_sh_r[0] : dr_r[0];
			tdo_oe_nxt = (tap_r == srom_pkg::TAP_SH_IR) || (tap_r == srom_pkg::TAP_SH_DR);
		end
	end

	always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			tap_r <= srom_pkg::TAP_RESET;
			ir_r <= srom_pkg::INS_IDCODE;
			ir_sh_r <= '0;
			dr_r <= '0;
			tdo_r <= 1'b1;
			tdo_oe_r <= 1'b0;
		end else begin
			tap_r <= tap_nxt;
			ir_r <= ir_nxt;
			ir_sh_r <= ir_sh_nxt;
			dr_r <= dr_nxt;
			tdo_r <= tdo_nxt;
			tdo_oe_r <= tdo_oe_nxt;
		end
	end

	assign TDO_OUT = tdo_r;
	assign TDO_OE_OUT = tdo_oe_r;
	assign isp_active = (ir_r == srom_pkg::INS_ISP_ENTER) || (ir_r == srom_pkg::INS_PROGRAM);
	assign ISP_ACTIVE_OUT = isp_active;
	assign PROG_READY_OUT = prog_ready;

	// ************************************************************
	// programming path
	// ************************************************************
	// a word pushed while the fifo is full is lost; software polls the ready bit
	srom_fifo #(
		.WIDTH(WORD_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_in(SYS_CLK_IN),
		.rst_n_in(RSTN_IN),
		.s_valid_in(push),
		.s_ready_out(prog_ready),
		.s_data_in(dr_r[WORD_W-1:0]),
		.m_valid_out(fifo_valid),
		.m_ready_in(isp_active),
		.m_data_out(fifo_data)
	);

	// entering programming restarts the write address
	always_comb begin
		wr_ptr_nxt = wr_ptr_r;
		if (ir_r == srom_pkg::INS_ISP_ENTER) begin
			wr_ptr_nxt = '0;
		end else if (fifo_valid && isp_active) begin
			wr_ptr_nxt = wr_ptr_r + 1'b1;
		end
	end

	always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			wr_ptr_r <= '0;
		end else begin
			wr_ptr_r <= wr_ptr_nxt;
		end
	end

	always_ff @(posedge SYS_CLK_IN) begin
		if (fifo_valid && isp_active) begin
			mem[wr_ptr_r] <= fifo_data;
		end
	end

	// ************************************************************
	// config pulse
	// ************************************************************
	always_comb begin
		pulse_cnt_nxt = pulse_cnt_r;
		if (cfg_start) begin
			pulse_cnt_nxt = TW'(srom_pkg::CFG_PULSE_CYC);
		end else if (pulse_cnt_r != '0) begin
			pulse_cnt_nxt = pulse_cnt_r - 1'b1;
		end
	end

	always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			pulse_cnt_r <= '0;
		end else begin
			pulse_cnt_r <= pulse_cnt_nxt;
		end
	end

	assign CONFIG_PULSE_N_OUT = 1'b0;
	assign CONFIG_PULSE_N_OE_OUT = pulse_cnt_r != '0;

	// ************************************************************
	// readout and cascade
	// ************************************************************
	assign enabled = ~cfg_r.ce_n & cfg_r.oe_rst_n & ~por_r;
	assign past_tc = addr_r > LAST_ADDRESS_COUNT;
	assign run = enabled & ~isp_active;

	// counter saturates one past the last bit so cascade stays low
	always_comb begin
		addr_nxt = addr_r;
		if (!enabled) begin
			addr_nxt = '0;
		end else if (cfg_rise && cfg_r.sel && !past_tc) begin
			addr_nxt = addr_r + 1'b1;
		end
		data_nxt = mem[addr_r[AW-1:BW]][BW'(WORD_W - 1) - addr_r[BW-1:0]];
		data_oe_nxt = run & ~past_tc;
		paced_nxt = 1'b1;
		if (DECOMP_EN_IN ? (run & ~past_tc) : run) begin
			paced_nxt = ~paced_r;
		end
	end

	always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			addr_r <= '0;
			data_r <= 1'b0;
			data_oe_r <= 1'b0;
			paced_r <= 1'b1;
			standby_r <= 1'b1;
		end else begin
			addr_r <= addr_nxt;
			data_r <= data_nxt;
			data_oe_r <= data_oe_nxt;
			paced_r <= paced_nxt;
			standby_r <= cfg_r.ce_n;
		end
	end

	assign SERIAL_DATA_OUT = data_r;
	assign SERIAL_DATA_OE_OUT = data_oe_r;
	assign PACED_CLOCK_OUTPUT_OUT = paced_r;
	assign STANDBY_OUT = standby_r;
	// straight from the pins so disabling frees the next part at once
	assign CASCADE_SELECT_N_OUT = ~(~CHIP_SEL_N_IN & OE_RESET_N_IN & past_tc);
endmodule
`default_nettype wire

// ==== srom_top_tb.sv ====
// self-checking bench of the configuration memory readout and test port
`timescale 1ns/1ps
`default_nettype none
module srom_top_tb;
	localparam int WORDS = 2;
	logic clk, rstn, sel, ce_n, dec, tck, tms, tdi, hold, q;
	logic oe_o, oe_oe, sd, sd_oe, csn, cp, cp_oe, pace, stby, tdo, tdo_oe, isp, rdy;
	logic cfg_clk, oe_wire, data_w, tdo_w;
	logic [7:0] lfsr;
	logic [7:0] words [WORDS];
	logic [31:0] cap;
	logic exp_q [$];
	int failures, check_count, cyc, n;
	// ************************************************************
	// clock, design and far side
	// ************************************************************
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	srom_top #(.WORDS(WORDS)) dut_u (.SYS_CLK_IN(clk), .RSTN_IN(rstn), .CFG_CLK_IN(cfg_clk), .CFG_CLK_SEL_IN(sel),
		.CHIP_SEL_N_IN(ce_n), .DECOMP_EN_IN(dec), .OE_RESET_N_IN(oe_wire), .OE_RESET_N_OUT(oe_o),
		.OE_RESET_N_OE_OUT(oe_oe), .SERIAL_DATA_OUT(sd), .SERIAL_DATA_OE_OUT(sd_oe), .CASCADE_SELECT_N_OUT(csn),
		.CONFIG_PULSE_N_OUT(cp), .CONFIG_PULSE_N_OE_OUT(cp_oe), .PACED_CLOCK_OUTPUT_OUT(pace),
		.STANDBY_OUT(stby), .TCK_IN(tck), .TMS_IN(tms), .TDI_IN(tdi), .TDO_OUT(tdo), .TDO_OE_OUT(tdo_oe),
		.ISP_ACTIVE_OUT(isp), .PROG_READY_OUT(rdy));
	srom_cfg_host p_u (.clk_in(clk), .hold_in(hold), .oe_drive_in(oe_oe), .data_in(sd), .data_oe_in(sd_oe),
		.cfg_clk_out(cfg_clk), .oe_wire_out(oe_wire), .data_wire_out(data_w));
	// undriven test output reads as one through its pull-up
	assign tdo_w = tdo_oe ? tdo : 1'b1;
	// ************************************************************
	// shared tasks
	// ************************************************************
	function automatic logic [7:0] next_rand(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// one test clock period, output sampled just before the rise
	task automatic tbit(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		tck = 1'b0;
		repeat (3) @(negedge clk);
		o = tdo_w;
		tck = 1'b1;
		repeat (2) @(negedge clk);
	endtask
	// idle to shift, n bits first bit first, update, back to idle
	task automatic scan(input logic ir, input int nb, input logic [31:0] din, output logic [31:0] dout);
		logic b;
		dout = 32'h0;
		tbit(1'b1, 1'b1, b);
		if (ir) begin
			tbit(1'b1, 1'b1, b);
		end
		tbit(1'b0, 1'b1, b);
		tbit(1'b0, 1'b1, b);
		for (int i = 0; i < nb; i++) begin
			tbit(i == nb - 1, din[i], b);
			dout[i] = b;
		end
		tbit(1'b1, 1'b1, b);
		tbit(1'b0, 1'b1, b);
	endtask
	// ************************************************************
	// watcher: compares each bit the far side samples
	// ************************************************************
	always @(posedge cfg_clk) begin
		if (sd_oe && exp_q.size() > 0) begin
			chk("serial bit", 32'(data_w), 32'(exp_q.pop_front()));
		end
	end
	// hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			complete_run();
		end
	end
	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		rstn = 1'b0;
		sel = 1'b1;
		ce_n = 1'b1;
		dec = 1'b1;
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
		hold = 1'b0;
		lfsr = 8'h16;
		repeat (2) @(negedge clk);
		chk("reset pull", 32'({oe_oe, oe_o}), 32'h2);
		rstn = 1'b1;
		repeat (srom_pkg::POR_HOLD_CYC - 2) @(negedge clk);
		chk("reset hold", 32'(oe_oe), 32'h1);
		repeat (4) @(negedge clk);
		chk("reset free", 32'(oe_wire), 32'h1);
		chk("standby float", 32'(sd_oe), 32'h0);
		chk("standby flag", 32'(stby), 32'h1);
		chk("paced idle", 32'(pace), 32'h1);
		$display("test reset done");
		// test port: identification, capture value, config pulse
		repeat (5) tbit(1'b1, 1'b1, q);
		tbit(1'b0, 1'b1, q);
		scan(1'b0, 32, 32'hffff_ffff, cap);
		chk("ident", cap, srom_pkg::ID_VALUE);
		scan(1'b1, 8, 32'(srom_pkg::INS_CONFIG), cap);
		chk("ir capture", cap, 32'(srom_pkg::IR_CAPTURE));
		chk("pulse on", 32'({cp_oe, cp}), 32'h2);
		n = 0;
		while (cp_oe && n < 400) begin
			@(negedge clk);
			n++;
		end
		chk("pulse end", 32'(n > 150 && n <= srom_pkg::CFG_PULSE_CYC), 32'h1);
		$display("test port done");
		// programming: data floats, words loaded with random values
		scan(1'b1, 8, 32'(srom_pkg::INS_ISP_ENTER), cap);
		ce_n = 1'b0;
		repeat (5) @(negedge clk);
		chk("isp float", 32'({isp, sd_oe}), 32'h2);
		ce_n = 1'b1;
		scan(1'b1, 8, 32'(srom_pkg::INS_PROGRAM), cap);
		for (int w = 0; w < WORDS; w++) begin
			words[w] = lfsr;
			lfsr = next_rand(lfsr);
			scan(1'b0, 8, 32'(words[w]), cap);
			chk("prog ready", 32'({cap[0], rdy}), 32'h3);
		end
		scan(1'b1, 8, 32'(srom_pkg::INS_BYPASS), cap);
		chk("isp off", 32'(isp), 32'h0);
		// bypass is one stage long: captured zero, then the first bit shifted in
		scan(1'b0, 2, 32'h1, cap);
		chk("bypass", cap, 32'h2);
		$display("test program done");
		// readout: word 0 first, msb first, then cascade hand-off
		for (int w = 0; w < WORDS; w++) begin
			for (int b = 7; b >= 0; b--) begin
				exp_q.push_back(words[w][b]);
			end
		end
		ce_n = 1'b0;
		repeat (4) @(negedge clk);
		chk("data drive", 32'({sd_oe, csn}), 32'h3);
		q = pace;
		@(negedge clk);
		chk("paced toggle", 32'(pace), 32'(!q));
		// clock input not selected: a rise must not step, first bit is seen twice
		sel = 1'b0;
		exp_q.push_front(words[0][7]);
		p_u.step(1);
		sel = 1'b1;
		p_u.step(WORDS * 8);
		repeat (2) @(negedge clk);
		chk("all bits", 32'(exp_q.size()), 32'h0);
		chk("cascade low", 32'(csn), 32'h0);
		chk("paced stop", 32'(pace), 32'h1);
		dec = 1'b0;
		@(negedge clk);
		q = pace;
		@(negedge clk);
		chk("paced free", 32'(pace), 32'(!q));
		dec = 1'b1;
		ce_n = 1'b1;
		#1;
		chk("cascade deselect", 32'(csn), 32'h1);
		@(negedge clk);
		ce_n = 1'b0;
		hold = 1'b1;
		#1;
		chk("cascade reset", 32'(csn), 32'h1);
		repeat (4) @(negedge clk);
		chk("reset float", 32'(sd_oe), 32'h0);
		hold = 1'b0;
		repeat (4) @(negedge clk);
		chk("counter cleared", 32'({csn, sd_oe}), 32'h3);
		$display("test readout done");
		complete_run();
	end
endmodule
`default_nettype wire
